// [bench/gis_host_model.sv]
// processor-side partner: register port master with write, read and service tasks
// assumes sys_clk is the block's clock and nobody else drives the register port
`timescale 1ns/1ps
module gis_host_model
    import gis_pkg::*;
(
    input wire logic sys_clk,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata
);
    // quiet port at time zero
    initial begin
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write; stale data inverted so nothing leans on a held value
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // one-cycle read; data only valid in the following cycle
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask

    // end of service: clear then restore mask to force a fresh edge
    task automatic service(input logic [DATA_W-1:0] m);
        wr(ADDR_INT, MASK_RESET);
        wr(ADDR_INT, m);
    endtask
endmodule

// [bench/gis_top_tb.sv]
// self-checking bench for the interrupt status and mask block
// assumes gis_host_model as register master; bench drives all condition inputs
`timescale 1ns/1ps
module gis_top_tb;
    import gis_pkg::*;
    logic sys_clk;
    logic arst_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, data_out_register, bus_data_in, q;
    logic reg_wr, reg_rd, data_out_strobe, handshake_hold, handshake_release;
    logic trigger_out, irq_n, eoi_n, atn_n, listener_active, byte_received;
    logic sec_mode, primary_addr_state, sec_addr_received, serial_poll_active;
    logic remote_state, device_clear_pending, undef_univ, undef_addr, cmd_deselect, trig_on;
    logic talker_active, talker_entry, listeners_accepted;
    int fail_count = 0;
    int n_compared = 0;
    // row: {eoi_n,atn_n,poll,devclr,undef_univ,undef_addr,deselect,trigger}, mask, status
    logic [23:0] rows [0:12] = '{24'hC06F10, 24'h406F92, 24'h006F10, 24'hE06F94,
        24'hD06F94, 24'hD26F10, 24'hC86F94, 24'hC46F94, 24'hC16FB0, 24'hC36F10,
        24'h400012, 24'hE00494, 24'hE06B14};

    gis_host_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    gis_top dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .eoi_n(eoi_n), .atn_n(atn_n), .listener_active(listener_active),
        .byte_received(byte_received), .sec_mode(sec_mode),
        .primary_addr_state(primary_addr_state), .sec_addr_received(sec_addr_received),
        .serial_poll_active(serial_poll_active), .remote_state(remote_state),
        .local_lockout(remote_state), .device_clear_pending(device_clear_pending),
        .undefined_universal_cmd(undef_univ), .undefined_addressed_cmd(undef_addr),
        .cmd_deselect(cmd_deselect), .listener_addressed(trig_on),
        .group_trigger_cmd(trig_on), .acceptor_ready(trig_on),
        .talker_active(talker_active), .talker_entry(talker_entry),
        .listeners_accepted(listeners_accepted), .bus_data_in(bus_data_in),
        .data_out_register(data_out_register), .data_out_strobe(data_out_strobe),
        .handshake_hold(handshake_hold), .handshake_release(handshake_release),
        .trigger_out(trigger_out), .irq_n(irq_n));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // watchdog well beyond the few hundred cycles the run needs
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end

    initial begin
        {eoi_n, atn_n} = 2'b11;
        {listener_active, byte_received, sec_mode, primary_addr_state} = 4'h0;
        {sec_addr_received, serial_poll_active, remote_state, device_clear_pending} = 4'h0;
        {undef_univ, undef_addr, cmd_deselect, trig_on, talker_active} = 5'h00;
        {talker_entry, listeners_accepted} = 2'b00;
        bus_data_in = 8'h00;
        arst_n = 1'b0;
        tick(5);
        arst_n <= 1'b1;
        chk({7'h00, irq_n}, 8'h01);
        tick(3);
        // level conditions through the table, mask without master enable
        foreach (rows[i]) begin
            @(posedge sys_clk);
            {eoi_n, atn_n, serial_poll_active, device_clear_pending} <= rows[i][23:20];
            {undef_univ, undef_addr, cmd_deselect, trig_on} <= rows[i][19:16];
            host_u.wr(ADDR_INT, rows[i][15:8]);
            tick(4);
            host_u.rd(ADDR_INT, q);
            chk(q, rows[i][7:0]);
            chk({7'h00, trigger_out}, {7'h00, rows[i][16] & ~rows[i][17]});
            chk({7'h00, handshake_release}, {7'h00, rows[i][17] & rows[i][16]});
            chk({7'h00, handshake_hold},
                {7'h00, ~rows[i][17] & (|rows[i][20:18] | rows[i][16])});
        end
        @(posedge sys_clk);
        {eoi_n, atn_n, serial_poll_active, trig_on} <= 4'hC;
        host_u.rd(3'h2, q);
        chk(q, 8'h00);
        // byte in: held, survives release, cleared by data read
        host_u.wr(ADDR_INT, 8'h81);
        @(posedge sys_clk);
        listener_active <= 1'b1;
        bus_data_in <= 8'hA5;
        byte_received <= 1'b1;
        @(posedge sys_clk);
        byte_received <= 1'b0;
        tick(2);
        chk({7'h00, irq_n}, 8'h00);
        chk({7'h00, handshake_hold}, 8'h01);
        host_u.rd(ADDR_INT, q);
        chk(q, 8'h91);
        chk({7'h00, irq_n}, 8'h01);
        host_u.wr(ADDR_AUX, 8'h10);
        // new condition while summary already high: no request
        host_u.wr(ADDR_INT, 8'h83);
        @(posedge sys_clk);
        eoi_n <= 1'b0;
        tick(6);
        chk({7'h00, irq_n}, 8'h01);
        host_u.rd(ADDR_INT, q);
        chk(q, 8'h93);
        host_u.service(8'h83);
        tick(2);
        chk({7'h00, irq_n}, 8'h00);
        host_u.rd(ADDR_DATA, q);
        chk(q, 8'hA5);
        chk({7'h00, handshake_hold}, 8'h00);
        // software reset while the pin is still low clears mask and releases it
        host_u.wr(ADDR_AUX, 8'h80);
        tick(2);
        chk({7'h00, irq_n}, 8'h01);
        host_u.rd(ADDR_INT, q);
        chk(q, 8'h12);
        @(posedge sys_clk);
        {eoi_n, listener_active} <= 2'b10;
        host_u.wr(ADDR_INT, 8'h6F);
        // byte out: set on talker entry, cleared by write, set on accept, hidden by atn
        @(posedge sys_clk);
        talker_active <= 1'b1;
        talker_entry <= 1'b1;
        @(posedge sys_clk);
        talker_entry <= 1'b0;
        host_u.rd(ADDR_INT, q);
        chk(q, 8'hD0);
        host_u.wr(ADDR_DATA, 8'h3C);
        #1 chk({7'h00, data_out_strobe}, 8'h01);
        host_u.rd(ADDR_INT, q);
        chk(q, 8'h10);
        chk(data_out_register, 8'h3C);
        @(posedge sys_clk);
        listeners_accepted <= 1'b1;
        @(posedge sys_clk);
        listeners_accepted <= 1'b0;
        atn_n <= 1'b0;
        tick(4);
        host_u.rd(ADDR_INT, q);
        chk(q, 8'h10);
        @(posedge sys_clk);
        {atn_n, talker_active} <= 2'b10;
        // secondary address flag cleared by release
        sec_mode <= 1'b1;
        primary_addr_state <= 1'b1;
        sec_addr_received <= 1'b1;
        @(posedge sys_clk);
        sec_addr_received <= 1'b0;
        host_u.rd(ADDR_INT, q);
        chk(q, 8'hD8);
        host_u.wr(ADDR_AUX, 8'h10);
        host_u.rd(ADDR_INT, q);
        chk(q, 8'hD0);
        // trigger flag cleared by release
        @(posedge sys_clk);
        trig_on <= 1'b1;
        tick(2);
        host_u.wr(ADDR_AUX, 8'h10);
        host_u.rd(ADDR_INT, q);
        chk(q & 8'h20, 8'h00);
        chk({7'h00, trigger_out}, 8'h00);
        // remote/local change latches, read clears it, command flag follows
        @(posedge sys_clk);
        trig_on <= 1'b0;
        remote_state <= 1'b1;
        tick(2);
        host_u.rd(ADDR_INT, q);
        chk(q, 8'hD4);
        host_u.rd(ADDR_CMD_STATUS, q);
        chk(q, 8'h78);
        host_u.rd(ADDR_CMD_STATUS, q);
        chk(q, 8'h70);
        host_u.rd(ADDR_INT, q);
        chk(q, 8'hD0);
        // hardware reset mid-run
        host_u.wr(ADDR_INT, 8'h84);
        @(posedge sys_clk);
        remote_state <= 1'b0;
        tick(3);
        chk({7'h00, irq_n}, 8'h00);
        arst_n <= 1'b0;
        tick(2);
        chk({7'h00, irq_n}, 8'h01);
        chk(reg_rdata, 8'h00);
        arst_n <= 1'b1;
        tick(4);
        host_u.rd(ADDR_INT, q);
        chk(q, 8'h10);
        stop_test();
    end
endmodule

// [design/gis_edge_req.sv]
// rising-edge request generator for the interrupt pin
// assumes summary and enable come from the same clock domain
`timescale 1ns/1ps
module gis_edge_req (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic summary,
    input wire logic enable,
    input wire logic ack,
    output logic irq_n
);
    logic summary_q;

    // remember last summary so only a fresh rise makes a request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            summary_q <= 1'b0;
        end else begin
            summary_q <= summary;
        end
    end

    // rise wins over a same-cycle status read so no request is lost
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n <= 1'b1;
        end else if (enable && summary && !summary_q) begin
            irq_n <= 1'b0;
        end else if (ack) begin
            irq_n <= 1'b1;
        end
    end
endmodule

// [design/gis_sync.sv]
// two flip-flop synchroniser for a vector of bus-side levels
// assumes asynchronous low reset already released cleanly
`timescale 1ns/1ps
module gis_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// [design/gis_top.sv]
// interrupt status and mask logic of an instrument bus interface adapter
// assumes condition inputs come from the interface state machines on the same
// clock, except eoi_n/atn_n which arrive straight from bus pins
`timescale 1ns/1ps
module gis_top
    import gis_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic eoi_n,
    input wire logic atn_n,
    input wire logic listener_active,
    input wire logic byte_received,
    input wire logic sec_mode,
    input wire logic primary_addr_state,
    input wire logic sec_addr_received,
    input wire logic serial_poll_active,
    input wire logic remote_state,
    input wire logic local_lockout,
    input wire logic device_clear_pending,
    input wire logic undefined_universal_cmd,
    input wire logic undefined_addressed_cmd,
    input wire logic cmd_deselect,
    input wire logic listener_addressed,
    input wire logic group_trigger_cmd,
    input wire logic acceptor_ready,
    input wire logic talker_active,
    input wire logic talker_entry,
    input wire logic listeners_accepted,
    input wire logic [DATA_W-1:0] bus_data_in,
    output logic [DATA_W-1:0] data_out_register,
    output logic data_out_strobe,
    output logic handshake_hold,
    output logic handshake_release,
    output logic trigger_out,
    output logic irq_n
);
    logic rst_s1;
    logic rst_n;
    logic eoi_low;
    logic atn_high;
    logic [1:0] pins_raw;
    logic [1:0] pins_sync;
    logic byte_in_flag;
    logic [DATA_W-1:0] data_in_register;
    logic last_byte_flag;
    logic remote_local_change;
    logic remote_q;
    logic cmd_flag;
    logic secondary_address_flag;
    logic trigger_flag;
    logic trig_ack;
    logic byte_out_flag;
    logic byte_out_latch;
    logic [DATA_W-1:0] interrupt_mask;
    logic [DATA_W-1:0] interrupt_status;
    logic [DATA_W-1:0] cmd_status;
    logic summary;
    logic wr_mask;
    logic rd_status;
    logic rd_cmd;
    logic rd_data;
    logic wr_data;
    logic release_wr;
    logic soft_reset;
    logic device_trigger_active;
    logic cmd_held;

    // reset release passes two flops so all logic leaves reset on one edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // bus management lines are asynchronous to the processor clock
    assign pins_raw = {~eoi_n, atn_n};
    gis_sync #(.WIDTH(2)) u_pin_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );
    assign eoi_low = pins_sync[1];
    assign atn_high = pins_sync[0];

    // register port decode
    assign wr_mask = reg_wr && (reg_addr == ADDR_INT);
    assign rd_status = reg_rd && (reg_addr == ADDR_INT);
    assign rd_cmd = reg_rd && (reg_addr == ADDR_CMD_STATUS);
    assign rd_data = reg_rd && (reg_addr == ADDR_DATA);
    assign wr_data = reg_wr && (reg_addr == ADDR_DATA);
    assign release_wr = reg_wr && (reg_addr == ADDR_AUX) && reg_wdata[AUX_RELEASE];
    assign soft_reset = reg_wr && (reg_addr == ADDR_AUX) && reg_wdata[AUX_SOFT_RESET];

    // byte-in: a new byte wins over a same-cycle read so nothing is dropped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_in_flag <= 1'b0;
            data_in_register <= ZERO_BYTE;
        end else if (listener_active && byte_received) begin
            byte_in_flag <= 1'b1;
            data_in_register <= bus_data_in;
        end else if (rd_data) begin
            byte_in_flag <= 1'b0;
        end
    end

    // last-byte is pure level, not qualified by the handshake
    assign last_byte_flag = eoi_low && atn_high;

    // change flag: a transition wins over the clearing read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_q <= 1'b0;
            remote_local_change <= 1'b0;
        end else begin
            remote_q <= remote_state;
            if (soft_reset) begin
                remote_local_change <= 1'b0;
            end else if (remote_state != remote_q) begin
                remote_local_change <= 1'b1;
            end else if (rd_cmd) begin
                remote_local_change <= 1'b0;
            end
        end
    end

    // command flag is combinational from its sources only
    assign cmd_held = !cmd_deselect
        && (device_clear_pending || undefined_universal_cmd || undefined_addressed_cmd);
    assign cmd_flag = serial_poll_active || remote_local_change || cmd_held;

    // secondary address: arrival wins over the release write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            secondary_address_flag <= 1'b0;
        end else if (sec_mode && primary_addr_state && sec_addr_received) begin
            secondary_address_flag <= 1'b1;
        end else if (release_wr) begin
            secondary_address_flag <= 1'b0;
        end
    end

    // trigger: release write acknowledges until the trigger state is left,
    // otherwise the still-true level would set the flag again at once
    assign device_trigger_active = !cmd_deselect && listener_addressed
        && group_trigger_cmd && acceptor_ready;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_ack <= 1'b0;
        end else if (!device_trigger_active) begin
            trig_ack <= 1'b0;
        end else if (release_wr) begin
            trig_ack <= 1'b1;
        end
    end
    assign trigger_flag = device_trigger_active && !trig_ack;
    assign trigger_out = trigger_flag;

    // byte-out latch; a talker event wins over the data write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_out_latch <= 1'b0;
        end else if (talker_entry || (talker_active && listeners_accepted)) begin
            byte_out_latch <= 1'b1;
        end else if (wr_data) begin
            byte_out_latch <= 1'b0;
        end
    end
    assign byte_out_flag = byte_out_latch && atn_high;

    // data out register loaded by the processor write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out_register <= ZERO_BYTE;
            data_out_strobe <= 1'b0;
        end else begin
            data_out_strobe <= wr_data;
            if (wr_data) begin
                data_out_register <= reg_wdata;
            end
        end
    end

    // acceptor handshake held while byte-in, trigger, secondary address or a held clear/undefined command awaits the processor
    assign handshake_hold = (byte_in_flag && !rd_data) || trigger_flag
        || secondary_address_flag || cmd_held;
    // a deselected trigger command completes without the processor
    assign handshake_release = rd_data || release_wr
        || (cmd_deselect && group_trigger_cmd && listener_addressed);

    // mask register, write only; cleared by either reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_mask <= MASK_RESET;
        end else if (soft_reset) begin
            interrupt_mask <= MASK_RESET;
        end else if (wr_mask) begin
            interrupt_mask <= reg_wdata;
        end
    end

    // masked summary over bits 0,1,2,3,5,6; bit 4 mask is ignored
    always_comb begin
        interrupt_status = ZERO_BYTE;
        interrupt_status[BIT_BYTE_IN] = byte_in_flag;
        interrupt_status[BIT_LAST] = last_byte_flag;
        interrupt_status[BIT_CMD] = cmd_flag;
        interrupt_status[BIT_SEC_ADDR] = secondary_address_flag;
        interrupt_status[BIT_ONE] = 1'b1;
        interrupt_status[BIT_TRIG] = trigger_flag;
        interrupt_status[BIT_BYTE_OUT] = byte_out_flag;
        summary = |(interrupt_status & interrupt_mask & SUMMARY_SOURCES);
        interrupt_status[BIT_SUMMARY] = summary;
    end

    always_comb begin
        cmd_status = ZERO_BYTE;
        cmd_status[CS_UNDEF_UNIV] = undefined_universal_cmd && !cmd_deselect;
        cmd_status[CS_DCAS] = device_clear_pending && !cmd_deselect;
        cmd_status[CS_SPAS] = serial_poll_active;
        cmd_status[CS_CHANGE] = remote_local_change;
        cmd_status[CS_ONE] = 1'b1;
        cmd_status[CS_LOK] = local_lockout;
        cmd_status[CS_REM] = remote_state;
        cmd_status[CS_UNDEF_ADDR] = undefined_addressed_cmd && !cmd_deselect;
    end

    // edge request; software reset releases the pin through ack and clears the mask so enable drops
    gis_edge_req u_req (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .summary(summary),
        .enable(interrupt_mask[BIT_SUMMARY]),
        .ack(rd_status || soft_reset),
        .irq_n(irq_n)
    );

    // read data stands one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= ZERO_BYTE;
        end else if (rd_status) begin
            reg_rdata <= interrupt_status;
        end else if (rd_cmd) begin
            reg_rdata <= cmd_status;
        end else if (rd_data) begin
            reg_rdata <= data_in_register;
        end else begin
            reg_rdata <= ZERO_BYTE;
        end
    end

    // assertions
    logic rd_status_q;
    logic summary_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_status_q <= 1'b0;
            summary_q <= 1'b0;
        end else begin
            rd_status_q <= rd_status;
            summary_q <= summary;
        end
    end

    bit_four_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_status |=> reg_rdata[BIT_ONE])
        else $error("status bit four read as zero");
    byte_in_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_data && !(listener_active && byte_received) |=> !byte_in_flag)
        else $error("byte-in not cleared by data read");
    byte_in_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        listener_active && byte_received |=> byte_in_flag && (handshake_hold || rd_data))
        else $error("byte-in or hold missing after received byte");
    last_byte_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        last_byte_flag == $past(!eoi_n && atn_n, 2))
        else $error("last-byte flag differs from pins");
    cmd_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        serial_poll_active |-> interrupt_status[BIT_CMD])
        else $error("command flag low during serial poll");
    change_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(remote_state) && !soft_reset |=> remote_local_change)
        else $error("change flag missed a transition");
    change_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_cmd && remote_state == remote_q |=> !remote_local_change)
        else $error("change flag not cleared by read");
    sec_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        release_wr && !(sec_mode && primary_addr_state && sec_addr_received)
        |=> !secondary_address_flag)
        else $error("secondary flag survived release");
    trig_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        release_wr && device_trigger_active |=> !trigger_flag)
        else $error("trigger flag survived release");
    trig_desel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cmd_deselect |-> !trigger_out)
        else $error("trigger set while deselected");
    byte_out_atn_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !atn_high |-> !interrupt_status[BIT_BYTE_OUT])
        else $error("byte-out high while atn low");
    irq_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(irq_n) |-> $past(summary && !summary_q && interrupt_mask[BIT_SUMMARY]))
        else $error("request without summary rise");
    irq_fire_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        summary && !summary_q && interrupt_mask[BIT_SUMMARY] |=> !irq_n)
        else $error("request not raised on summary rise");
    irq_ack_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_status_q && !irq_n |-> $past(summary && !summary_q && interrupt_mask[BIT_SUMMARY]))
        else $error("request stayed low after status read");

    irq_cov: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(irq_n));
    trig_cov: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(trigger_out));
    change_cov: cover property (@(posedge sys_clk) disable iff (!rst_n)
        rd_cmd && remote_local_change);
    byte_out_cov: cover property (@(posedge sys_clk) disable iff (!rst_n)
        wr_data && byte_out_latch);
endmodule

// [shared/gis_pkg.sv]
// package for the bus interface adapter interrupt status and mask block
// assumes a single processor-side clock; no other file defines these names
package gis_pkg;
    localparam int CLK_MHZ = 50;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    // register indices on the processor port (status read / mask write share one)
    localparam logic [ADDR_W-1:0] ADDR_INT = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CMD_STATUS = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_AUX = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h7;
    // interrupt status field positions
    localparam int BIT_BYTE_IN = 0;
    localparam int BIT_LAST = 1;
    localparam int BIT_CMD = 2;
    localparam int BIT_SEC_ADDR = 3;
    localparam int BIT_ONE = 4;
    localparam int BIT_TRIG = 5;
    localparam int BIT_BYTE_OUT = 6;
    localparam int BIT_SUMMARY = 7;
    // command status field positions
    localparam int CS_UNDEF_UNIV = 0;
    localparam int CS_DCAS = 1;
    localparam int CS_SPAS = 2;
    localparam int CS_CHANGE = 3;
    localparam int CS_ONE = 4;
    localparam int CS_LOK = 5;
    localparam int CS_REM = 6;
    localparam int CS_UNDEF_ADDR = 7;
    // auxiliary command: handshake release and software reset bits
    localparam int AUX_RELEASE = 4;
    localparam int AUX_SOFT_RESET = 7;
    localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] SUMMARY_SOURCES = 8'h6F;
endpackage
